// ===== verilog/fifo_port_pkg.sv
// Constants shared by the port-side FIFO control block
package fifo_port_pkg;
   // ***************************************************************
   // Sizes
   // ***************************************************************
   localparam int DATA_W = 36;
   localparam int ADDR_W = 6;
   localparam int PTR_W  = 7;
   localparam int LANE_W = 9;
   localparam int LANES  = 4;
   localparam int DEPTH  = 64;
   localparam logic [PTR_W-1:0] DEPTH_COUNT = 7'h40;
   localparam logic [PTR_W-1:0] EMPTY_COUNT = 7'h00;
   localparam logic [PTR_W-1:0] PTR_RESET   = 7'h00;
   localparam logic [DATA_W-1:0] DATA_RESET = 36'h0;

   // ***************************************************************
   // Preset almost-full offsets, chosen by the two offset selects
   // ***************************************************************
   localparam logic [PTR_W-1:0] OFFSET_SEL0 = 7'h10;
   localparam logic [PTR_W-1:0] OFFSET_SEL1 = 7'h0C;
   localparam logic [PTR_W-1:0] OFFSET_SEL2 = 7'h08;
   localparam logic [PTR_W-1:0] OFFSET_SEL3 = 7'h04;

   // ***************************************************************
   // Bit positions inside the synchronised pin vector
   // ***************************************************************
   localparam int A_CLK     = 0;
   localparam int A_SEL_N   = 1;
   localparam int A_EN      = 2;
   localparam int A_WR      = 3;
   localparam int A_MBX     = 4;
   localparam int A_PG      = 5;
   localparam int A_DATA    = 6;
   localparam int B_CLK     = 42;
   localparam int B_SEL_N   = 43;
   localparam int B_EN      = 44;
   localparam int B_WR      = 45;
   localparam int B_SZ_LO   = 46;
   localparam int B_SZ_HI   = 47;
   localparam int B_DATA    = 48;
   localparam int ODD_SEL   = 84;
   localparam int FS_LO     = 85;
   localparam int FS_HI     = 86;
   localparam int PIN_W     = 87;
endpackage

// ===== verilog/fifo_port_ctrl.sv
// Port-side control of a 64x36 FIFO with mailboxes and port A parity
//
// What this block does
// R01 - Port A acts only when selected and enabled
// R02 - Port B acts only when selected and enabled
// R03 - Empty flag low blocks FIFO reads
// R04 - Empty low at reset, high two edges later
// R05 - Full flag low blocks FIFO writes
// R06 - Full low at reset, high two edges later
// R07 - Offset selects latched when reset releases
// R08 - Mailbox select redirects port A to mailboxes
// R09 - Port A outputs show mailbox two
// R10 - Mailbox one write drops its flag, locks
// R11 - Port B mailbox read raises mailbox one flag
// R12 - Mailbox two write drops its flag, locks
// R13 - Port A mailbox read raises mailbox two flag
// R14 - Both mailbox flags high during reset
// R15 - Parity type input picks odd or even
// R16 - Generated parity follows the parity type
// R17 - Any failing port A lane flags error
// R18 - Error forced high while port A is set up for a mailbox read with parity generation
// R19 - Reset held over four edges each port
// R20 - Write select high writes, outputs float
// R21 - Both size selects pick the port B mailbox
// R22 - Almost full when free space within offset
// R23 - Qualified port A write stores FIFO word
`timescale 1ns/1ps
module fifo_port_ctrl (
   input  wire logic                                core_clk,
   input  wire logic                                reset_n,
   input  wire logic                                port_a_clock,
   input  wire logic                                port_a_select_n,
   input  wire logic                                port_a_enable,
   input  wire logic                                port_a_write_not_read,
   input  wire logic                                port_a_mailbox_select,
   input  wire logic                                port_a_parity_generate,
   input  wire logic [fifo_port_pkg::DATA_W-1:0]    port_a_data_in,
   output logic      [fifo_port_pkg::DATA_W-1:0]    port_a_data_out,
   output logic                                     port_a_data_oe,
   output logic                                     port_a_parity_error_n,
   input  wire logic                                port_b_clock,
   input  wire logic                                port_b_select_n,
   input  wire logic                                port_b_enable,
   input  wire logic                                port_b_write_not_read,
   input  wire logic                                port_b_size_select_lo,
   input  wire logic                                port_b_size_select_hi,
   input  wire logic [fifo_port_pkg::DATA_W-1:0]    port_b_data_in,
   output logic      [fifo_port_pkg::DATA_W-1:0]    port_b_data_out,
   output logic                                     port_b_data_oe,
   input  wire logic                                parity_odd_select,
   input  wire logic                                offset_select_lo,
   input  wire logic                                offset_select_hi,
   output logic                                     empty_flag_n,
   output logic                                     full_flag_n,
   output logic                                     almost_full_flag_n,
   output logic                                     mailbox_one_flag_n,
   output logic                                     mailbox_two_flag_n
);
   import fifo_port_pkg::*;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   // No reset here: the chain must already hold live pin levels when
   // reset releases, so the offset selects can be caught at once.
   logic [PIN_W-1:0]  pin_meta;
   logic [PIN_W-1:0]  pin_sync;
   logic              a_clk_prev;
   logic              b_clk_prev;

   always_ff @(posedge core_clk) begin
      pin_meta   <= {offset_select_hi, offset_select_lo, parity_odd_select,
                     port_b_data_in, port_b_size_select_hi, port_b_size_select_lo,
                     port_b_write_not_read, port_b_enable, port_b_select_n,
                     port_b_clock, port_a_data_in, port_a_parity_generate,
                     port_a_mailbox_select, port_a_write_not_read, port_a_enable,
                     port_a_select_n, port_a_clock};
      pin_sync   <= pin_meta;
      a_clk_prev <= pin_sync[A_CLK];
      b_clk_prev <= pin_sync[B_CLK];
   end

   logic               a_sel_n, a_en, a_wr, a_mbx, a_pg, odd_sel;
   logic               b_sel_n, b_en, b_wr, b_mbx;
   logic [DATA_W-1:0]  a_data, b_data;
   logic               a_edge, b_edge;

   assign a_sel_n = pin_sync[A_SEL_N];
   assign a_en    = pin_sync[A_EN];
   assign a_wr    = pin_sync[A_WR];
   assign a_mbx   = pin_sync[A_MBX];
   assign a_pg    = pin_sync[A_PG];
   assign a_data  = pin_sync[A_DATA +: DATA_W];
   assign b_sel_n = pin_sync[B_SEL_N];
   assign b_en    = pin_sync[B_EN];
   assign b_wr    = pin_sync[B_WR];
   assign b_data  = pin_sync[B_DATA +: DATA_W];
   assign odd_sel = pin_sync[ODD_SEL];
   // R21 - mailbox size code
   assign b_mbx   = pin_sync[B_SZ_LO] & pin_sync[B_SZ_HI];
   assign a_edge  = pin_sync[A_CLK] & ~a_clk_prev;
   assign b_edge  = pin_sync[B_CLK] & ~b_clk_prev;

   // ***************************************************************
   // Access qualification
   // ***************************************************************
   logic a_access, b_access, a_write, a_read, b_write, b_read;
   logic a_fifo_write, a_mb1_write, a_mb2_read;
   logic b_fifo_read, b_mb1_read, b_mb2_write;

   // R01 - select low and enable high
   assign a_access     = a_edge & ~a_sel_n & a_en;
   // R02 - select low and enable high
   assign b_access     = b_edge & ~b_sel_n & b_en;
   // R20 - write select high means write
   assign a_write      = a_access & a_wr;
   assign a_read       = a_access & ~a_wr;
   assign b_write      = b_access & b_wr;
   assign b_read       = b_access & ~b_wr;
   // R05 - full blocks FIFO writes
   assign a_fifo_write = a_write & ~a_mbx & full_flag_n;
   // R08 - mailbox select redirects port A
   assign a_mb1_write  = a_write & a_mbx & mailbox_one_flag_n;
   assign a_mb2_read   = a_read & a_mbx;
   // R03 - empty blocks FIFO reads
   assign b_fifo_read  = b_read & ~b_mbx & empty_flag_n;
   assign b_mb1_read   = b_read & b_mbx;
   // R12 - locked while flag low
   assign b_mb2_write  = b_write & b_mbx & mailbox_two_flag_n;

   // ***************************************************************
   // FIFO storage and pointers
   // ***************************************************************
   logic [DATA_W-1:0] mem [DEPTH];
   logic [PTR_W-1:0]  wr_ptr, rd_ptr;
   logic [PTR_W-1:0]  next_wr_ptr, next_rd_ptr, next_fill, next_free;

   assign next_wr_ptr = wr_ptr + PTR_W'(a_fifo_write);
   assign next_rd_ptr = rd_ptr + PTR_W'(b_fifo_read);
   assign next_fill   = next_wr_ptr - next_rd_ptr;
   assign next_free   = DEPTH_COUNT - next_fill;

   // R23 - store word at write pointer
   always_ff @(posedge core_clk) begin
      if (a_fifo_write) begin
         mem[wr_ptr[ADDR_W-1:0]] <= a_data;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= PTR_RESET;
         rd_ptr <= PTR_RESET;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // ***************************************************************
   // Empty flag on port B edges
   // ***************************************************************
   logic empty_pipe;

   // R04 - two port B edges to rise
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         empty_pipe   <= 1'b0;
         empty_flag_n <= 1'b0;
      end else if (b_edge) begin
         empty_pipe   <= (next_fill != EMPTY_COUNT);
         empty_flag_n <= empty_pipe & (next_fill != EMPTY_COUNT);
      end
   end

   // ***************************************************************
   // Full and almost-full flags on port A edges
   // ***************************************************************
   logic             full_pipe;
   logic             offset_loaded;
   logic [PTR_W-1:0] offset;

   // R06 - two port A edges to rise
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         full_pipe   <= 1'b0;
         full_flag_n <= 1'b0;
      end else if (a_edge) begin
         full_pipe   <= (next_fill != DEPTH_COUNT);
         full_flag_n <= full_pipe & (next_fill != DEPTH_COUNT);
      end
   end

   // R07 - catch offset selects after release
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         offset_loaded <= 1'b0;
         offset        <= OFFSET_SEL0;
      end else if (!offset_loaded) begin
         offset_loaded <= 1'b1;
         case ({pin_sync[FS_HI], pin_sync[FS_LO]})
            2'h0:    offset <= OFFSET_SEL0;
            2'h1:    offset <= OFFSET_SEL1;
            2'h2:    offset <= OFFSET_SEL2;
            default: offset <= OFFSET_SEL3;
         endcase
      end
   end

   // R22 - free space within offset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         almost_full_flag_n <= 1'b1;
      end else if (a_edge) begin
         almost_full_flag_n <= (next_free > offset);
      end
   end

   // ***************************************************************
   // Mailboxes
   // ***************************************************************
   logic [DATA_W-1:0] mailbox_one, mailbox_two;

   // R10 - write drops flag, further writes ignored
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mailbox_one <= DATA_RESET;
      end else if (a_mb1_write) begin
         mailbox_one <= a_data;
      end
   end

   // R14 - flags high during reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mailbox_one_flag_n <= 1'b1;
      end else if (b_mb1_read) begin
         // R11 - port B mailbox read frees it
         mailbox_one_flag_n <= 1'b1;
      end else if (a_mb1_write) begin
         mailbox_one_flag_n <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mailbox_two <= DATA_RESET;
      end else if (b_mb2_write) begin
         mailbox_two <= b_data;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mailbox_two_flag_n <= 1'b1;
      end else if (a_mb2_read) begin
         // R13 - port A mailbox read frees it
         mailbox_two_flag_n <= 1'b1;
      end else if (b_mb2_write) begin
         // R12 - write drops flag
         mailbox_two_flag_n <= 1'b0;
      end
   end

   // ***************************************************************
   // Parity
   // ***************************************************************
   // Odd parity: the nine bits of a lane xor to one
   function automatic logic lanes_ok(input logic [DATA_W-1:0] d, input logic odd);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < LANES; i++) begin
         ok = ok & ((^d[i*LANE_W +: LANE_W]) == odd);
      end
      return ok;
   endfunction

   function automatic logic [DATA_W-1:0] add_parity(input logic [DATA_W-1:0] d,
                                                    input logic            odd);
      logic [DATA_W-1:0] r;
      r = d;
      for (int i = 0; i < LANES; i++) begin
         r[i*LANE_W + LANE_W - 1] = (^d[i*LANE_W +: LANE_W-1]) ^ odd;
      end
      return r;
   endfunction

   logic gen_setup;
   assign gen_setup = ~a_sel_n & a_en & ~a_wr & a_mbx & a_pg;

   // R17 - any lane failing drops the flag
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_a_parity_error_n <= 1'b1;
      end else begin
         // R15 - parity type from input; R18 - mailbox read setup with generation forces high
         port_a_parity_error_n <= gen_setup | lanes_ok(a_data, odd_sel);
      end
   end

   // ***************************************************************
   // Output data and enables
   // ***************************************************************
   // R09 - port A shows mailbox two, with its lane parity bits regenerated while a_pg is high
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_a_data_out <= DATA_RESET;
      end else if (a_pg) begin
         // R16 - generated parity type
         port_a_data_out <= add_parity(mailbox_two, odd_sel);
      end else begin
         port_a_data_out <= mailbox_two;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_b_data_out <= DATA_RESET;
      end else if (b_fifo_read) begin
         port_b_data_out <= mem[rd_ptr[ADDR_W-1:0]];
      end else if (b_mb1_read) begin
         port_b_data_out <= mailbox_one;
      end
   end

   // R20 - float while selected for write or deselected
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_a_data_oe <= 1'b0;
         port_b_data_oe <= 1'b0;
      end else begin
         port_a_data_oe <= ~a_sel_n & ~a_wr;
         port_b_data_oe <= ~b_sel_n & ~b_wr;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   full_blocks_a:   assert property ((a_write && !a_mbx && !full_flag_n) |=> $stable(wr_ptr)) // R05
      else $error("FIFO write taken while full");
   empty_blocks_a:  assert property ((b_read && !b_mbx && !empty_flag_n) |=> $stable(rd_ptr)) // R03
      else $error("FIFO read taken while empty");
   empty_rise_a:    assert property ($rose(empty_flag_n) |-> $past(b_edge) && empty_pipe) // R04
      else $error("Empty flag rose without two port B edges");
   full_rise_a:     assert property ($rose(full_flag_n) |-> $past(a_edge) && full_pipe) // R06
      else $error("Full flag rose without two port A edges");
   mb1_lock_a:      assert property ((!mailbox_one_flag_n && !b_mb1_read) |=> $stable(mailbox_one)) // R10
      else $error("Mailbox one changed while locked");
   mb1_write_a:     assert property ((a_mb1_write && !b_mb1_read) |=> !mailbox_one_flag_n && mailbox_one == $past(a_data)) // R10
      else $error("Mailbox one write lost");
   mb1_free_a:      assert property (b_mb1_read |=> mailbox_one_flag_n) // R11
      else $error("Mailbox one flag not raised by port B read");
   mb2_write_a:     assert property ((b_mb2_write && !a_mb2_read) |=> !mailbox_two_flag_n && mailbox_two == $past(b_data)) // R12
      else $error("Mailbox two write lost");
   mb2_free_a:      assert property (a_mb2_read |=> mailbox_two_flag_n) // R13
      else $error("Mailbox two flag not raised by port A read");
   parity_force_a:  assert property (gen_setup |=> port_a_parity_error_n) // R18
      else $error("Parity error shown during parity generation");
   float_a:         assert property (a_sel_n |=> !port_a_data_oe) // R01
      else $error("Port A driven while deselected");
   mb2_show_a:      assert property (!a_pg ##1 !a_pg |-> port_a_data_out == $past(mailbox_two)) // R09
      else $error("Port A output is not mailbox two");

   fill_up_c:   cover property (!full_flag_n ##[1:1000] b_fifo_read);
   mb1_hand_c:  cover property (a_mb1_write ##[1:1000] b_mb1_read);
   parity_err_c: cover property (!port_a_parity_error_n);
endmodule

// ===== bench/port_host_model.sv
// Far-side bus masters of both FIFO ports, with free-running port clocks
`timescale 1ns/1ps
module port_host_model (
   input  wire logic                            core_clk,
   output logic                                 port_a_clock,
   output logic                                 port_a_select_n,
   output logic                                 port_a_enable,
   output logic                                 port_a_write_not_read,
   output logic                                 port_a_mailbox_select,
   output logic                                 port_a_parity_generate,
   output logic [fifo_port_pkg::DATA_W-1:0]     port_a_data_in,
   output logic                                 port_b_clock,
   output logic                                 port_b_select_n,
   output logic                                 port_b_enable,
   output logic                                 port_b_write_not_read,
   output logic                                 port_b_size_select_lo,
   output logic                                 port_b_size_select_hi,
   output logic [fifo_port_pkg::DATA_W-1:0]     port_b_data_in
);
   import fifo_port_pkg::*;
   logic [2:0] a_div;
   logic [2:0] b_div;
   // ****************
   // Port clocks
   // ****************
   initial begin
      a_div = 3'h0;
      b_div = 3'h0;
      port_a_clock = 1'b0;
      port_b_clock = 1'b0;
      port_a_select_n = 1'b1;
      port_a_enable = 1'b0;
      port_a_write_not_read = 1'b0;
      port_a_mailbox_select = 1'b0;
      port_a_parity_generate = 1'b0;
      port_a_data_in = 36'h0;
      port_b_select_n = 1'b1;
      port_b_enable = 1'b0;
      port_b_write_not_read = 1'b0;
      port_b_size_select_lo = 1'b0;
      port_b_size_select_hi = 1'b0;
      port_b_data_in = 36'h0;
   end
   // Phases of 5 and 6 core cycles keep the two ports unrelated
   always @(negedge core_clk) begin
      a_div <= (a_div == 3'h4) ? 3'h0 : a_div + 3'h1;
      if (a_div == 3'h4) begin
         port_a_clock <= ~port_a_clock;
      end
   end
   always @(negedge core_clk) begin
      b_div <= (b_div == 3'h5) ? 3'h0 : b_div + 3'h1;
      if (b_div == 3'h5) begin
         port_b_clock <= ~port_b_clock;
      end
   end
   // ****************
   // Bus cycles, set on a port clock fall, held across the next rise
   // ****************
   // held request
   task automatic a_pins(input logic sel_n, en, wr, mbx, pg, input logic [DATA_W-1:0] d);
      @(negedge port_a_clock);
      port_a_select_n = sel_n;
      port_a_enable = en;
      port_a_write_not_read = wr;
      port_a_mailbox_select = mbx;
      port_a_parity_generate = pg;
      port_a_data_in = d;
   endtask
   // Released bus shows the inverse of its last word
   task automatic a_idle;
      port_a_select_n = 1'b1;
      port_a_enable = 1'b0;
      port_a_data_in = ~port_a_data_in;
   endtask
   task automatic a_cycle(input logic wr, mbx, input logic [DATA_W-1:0] d);
      a_pins(1'b0, 1'b1, wr, mbx, 1'b0, d);
      @(negedge port_a_clock);
      a_idle();
   endtask
   task automatic b_pins(input logic sel_n, en, wr, sz, input logic [DATA_W-1:0] d);
      @(negedge port_b_clock);
      port_b_select_n = sel_n;
      port_b_enable = en;
      port_b_write_not_read = wr;
      port_b_size_select_lo = sz;
      port_b_size_select_hi = sz;
      port_b_data_in = d;
   endtask
   task automatic b_idle;
      port_b_select_n = 1'b1;
      port_b_enable = 1'b0;
      port_b_data_in = ~port_b_data_in;
   endtask
   task automatic b_cycle(input logic wr, sz, input logic [DATA_W-1:0] d);
      b_pins(1'b0, 1'b1, wr, sz, d);
      @(negedge port_b_clock);
      b_idle();
   endtask
endmodule

// ===== bench/fifo_port_flags_mailbox_parity_tb_top.sv
// Self-checking testbench of the port-side FIFO control block
`timescale 1ns/1ps
module fifo_port_flags_mailbox_parity_tb_top;
   import fifo_port_pkg::*;
   logic              core_clk, reset_n, parity_odd_select, offset_select_lo, offset_select_hi;
   logic              port_a_clock, port_a_select_n, port_a_enable, port_a_write_not_read;
   logic              port_a_mailbox_select, port_a_parity_generate, port_a_data_oe;
   logic              port_a_parity_error_n, port_b_clock, port_b_select_n, port_b_enable;
   logic              port_b_write_not_read, port_b_size_select_lo, port_b_size_select_hi;
   logic              port_b_data_oe, empty_flag_n, full_flag_n, almost_full_flag_n;
   logic              mailbox_one_flag_n, mailbox_two_flag_n;
   logic [DATA_W-1:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
   int                failures;
   int                checks;
   fifo_port_ctrl u_fifo_port_ctrl (.core_clk, .reset_n, .port_a_clock, .port_a_select_n,
      .port_a_enable, .port_a_write_not_read, .port_a_mailbox_select, .port_a_parity_generate,
      .port_a_data_in, .port_a_data_out, .port_a_data_oe, .port_a_parity_error_n,
      .port_b_clock, .port_b_select_n, .port_b_enable, .port_b_write_not_read,
      .port_b_size_select_lo, .port_b_size_select_hi, .port_b_data_in, .port_b_data_out,
      .port_b_data_oe, .parity_odd_select, .offset_select_lo, .offset_select_hi,
      .empty_flag_n, .full_flag_n, .almost_full_flag_n, .mailbox_one_flag_n,
      .mailbox_two_flag_n);
   port_host_model u_port_host_model (.core_clk, .port_a_clock, .port_a_select_n,
      .port_a_enable, .port_a_write_not_read, .port_a_mailbox_select, .port_a_parity_generate,
      .port_a_data_in, .port_b_clock, .port_b_select_n, .port_b_enable, .port_b_write_not_read,
      .port_b_size_select_lo, .port_b_size_select_hi, .port_b_data_in);
   always #10 core_clk = ~core_clk;
   // ****************
   // Helpers
   // ****************
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checks++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask
   task automatic b_edges(input int n);
      repeat (n) @(negedge port_b_clock);
   endtask
   function automatic logic [DATA_W-1:0] with_parity(logic [DATA_W-1:0] d, logic odd);
      logic [DATA_W-1:0] r;
      r = d;
      for (int i = 0; i < LANES; i++) begin
         r[i*LANE_W+8] = (^d[i*LANE_W +: 8]) ^ odd;
      end
      return r;
   endfunction
   function automatic logic lanes_ok(logic [DATA_W-1:0] d, logic odd);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < LANES; i++) begin
         ok = ok & ((^d[i*LANE_W +: LANE_W]) == odd);
      end
      return ok;
   endfunction
   task automatic final_report;
      if (failures == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic reset_scenario;
      repeat (20) @(negedge core_clk);
      // four edges of each port clock under reset
      repeat (4) @(posedge port_b_clock);
      check({empty_flag_n, full_flag_n}, 36'h0);
      check({mailbox_one_flag_n, mailbox_two_flag_n}, 36'h3);
      @(negedge port_a_clock);
      reset_n = 1'b1;
      @(negedge port_a_clock);
      check(full_flag_n, 1'b0);
      @(negedge port_a_clock);
      check(full_flag_n, 1'b1);
   endtask
   task automatic flow_scenario;
      u_port_host_model.a_pins(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 36'h1_1111_1111);
      u_port_host_model.a_pins(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 36'h2_2222_2222);
      @(negedge port_a_clock);
      u_port_host_model.a_idle();
      b_edges(3);
      check(empty_flag_n, 1'b0);
      u_port_host_model.b_cycle(1'b0, 1'b0, 36'h0);
      check(port_b_data_out, DATA_RESET);
      u_port_host_model.a_cycle(1'b1, 1'b0, 36'h1_2345_6789);
      check(empty_flag_n, 1'b0);
      b_edges(3);
      check(empty_flag_n, 1'b1);
      u_port_host_model.a_cycle(1'b1, 1'b0, 36'h9_8765_4321);
      u_port_host_model.b_pins(1'b0, 1'b0, 1'b0, 1'b0, 36'h0);
      @(negedge port_b_clock);
      check(port_b_data_oe, 1'b1);
      u_port_host_model.b_idle();
      check(port_b_data_out, DATA_RESET);
      u_port_host_model.b_cycle(1'b0, 1'b0, 36'h0);
      check(port_b_data_out, 36'h1_2345_6789);
      u_port_host_model.b_cycle(1'b0, 1'b0, 36'h0);
      check(port_b_data_out, 36'h9_8765_4321);
      b_edges(3);
      check(empty_flag_n, 1'b0);
      check(port_b_data_oe, 1'b0);
   endtask
   task automatic mailbox_scenario;
      u_port_host_model.a_cycle(1'b1, 1'b1, 36'hA_0000_0001);
      check(mailbox_one_flag_n, 1'b0);
      u_port_host_model.a_cycle(1'b1, 1'b1, 36'hA_0000_0002);
      b_edges(3);
      check(empty_flag_n, 1'b0);
      u_port_host_model.b_cycle(1'b0, 1'b1, 36'h0);
      check(port_b_data_out, 36'hA_0000_0001);
      check(mailbox_one_flag_n, 1'b1);
      u_port_host_model.b_cycle(1'b1, 1'b1, 36'hB_0000_0003);
      check(mailbox_two_flag_n, 1'b0);
      u_port_host_model.b_cycle(1'b1, 1'b1, 36'hB_0000_0004);
      u_port_host_model.a_pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 36'h0_0000_0001);
      parity_odd_select = 1'b1;
      @(negedge port_a_clock);
      check(port_a_parity_error_n, 1'b1);
      check(port_a_data_oe, 1'b1);
      check(port_a_data_out, with_parity(36'hB_0000_0003, 1'b1));
      check(mailbox_two_flag_n, 1'b1);
      u_port_host_model.a_idle();
      repeat (5) @(negedge core_clk);
      check(port_a_data_oe, 1'b0);
   endtask
   task automatic parity_scenario;
      logic [DATA_W-1:0] pat [3];
      pat = '{36'h0_0000_0000, 36'h0_0000_0001, 36'h0_0804_0201};
      for (int k = 0; k < 6; k++) begin
         u_port_host_model.a_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, pat[k/2]);
         parity_odd_select = k[0];
         @(negedge port_a_clock);
         check(port_a_parity_error_n, lanes_ok(pat[k/2], k[0]));
      end
   endtask
   task automatic fill_scenario(input int off);
      for (int i = 0; i < DEPTH; i++) begin
         u_port_host_model.a_cycle(1'b1, 1'b0, 36'h5_0000_0000 + DATA_W'(i));
         if (i >= DEPTH - 4 - off) begin
            @(negedge port_a_clock);
            check(almost_full_flag_n, (DEPTH - 1 - i) > off);
         end
      end
      check(full_flag_n, 1'b0);
      u_port_host_model.a_cycle(1'b1, 1'b0, 36'hF_FFFF_FFFF);
      for (int i = 0; i < DEPTH; i++) begin
         u_port_host_model.b_cycle(1'b0, 1'b0, 36'h0);
         check(port_b_data_out, 36'h5_0000_0000 + DATA_W'(i));
      end
      b_edges(3);
      check(empty_flag_n, 1'b0);
      u_port_host_model.b_cycle(1'b0, 1'b0, 36'h0);
      check(port_b_data_out, 36'h5_0000_003F);
      check(full_flag_n, 1'b1);
   endtask
   // Whole run is about 135 us; the limit leaves ample margin
   initial begin
      #300000;
      failures++;
      final_report();
   end
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      failures = 0;
      checks = 0;
      parity_odd_select = 1'b0;
      offset_select_lo = 1'b1;
      offset_select_hi = 1'b1;
      reset_scenario();
      flow_scenario();
      mailbox_scenario();
      parity_scenario();
      fill_scenario(int'(OFFSET_SEL3));
      reset_n = 1'b0;
      offset_select_hi = 1'b0;
      reset_scenario();
      fill_scenario(int'(OFFSET_SEL1));
      final_report();
   end
endmodule
